// ---- pkg/amd_defs.svh ----
// Purpose: Named constants for the addressing and move decoder
// Assumes: One core clock; memory and special registers answer one cycle after a strobe
// Notes: Opcode values, state counts and register indexes live here only
// Notes on behaviour
// - Page address is page register then offset
// - Page decrement writes byte minus one back
// - Table loads C from PC+3+A, B next
// - Immediate operand is byte after opcode
// - Word operand fetched low byte then high
// - Direct address is instruction word, no register
// - Skip costs 4 per opcode, 3 per data
// - Accumulator to short register, 4 states
// - Wide codes pick upper or lower half
// - Short register to accumulator, 4 states
// - Moves clear skip and both string flags
// - Special write accepts listed codes, 10 states
// - Special read accepts listed codes, 10 states
// - Direct load, address bytes low high, 17
// - Direct store, same coding, 17 states
`ifndef AMD_DEFS_SVH
`define AMD_DEFS_SVH
// Opcode fields
`define AMD_OP_MOVRA 5'h03
`define AMD_OP_MOVAR 5'h01
`define AMD_OP_PAGE_DECREMENT_OP 8'h30
`define AMD_OP_ADI 8'h46
`define AMD_OP_LXI 4'h4
`define AMD_OP_SRR 8'h4C
`define AMD_OP_SRW 8'h4D
`define AMD_OP_PFX 8'h70
`define AMD_OP_TBL 8'h48
`define AMD_SUB_TBL 8'hA0
`define AMD_SUB_LDM 5'h0D
`define AMD_SUB_STM 5'h0F
`define AMD_SR_TAG 2'h3
// Executed state counts
`define AMD_ST_MOV1 8'h04
`define AMD_ST_SR 8'h0A
`define AMD_ST_DIR 8'h11
`define AMD_ST_PAGE_DECREMENT_OP 8'h0A
`define AMD_ST_ADI 8'h07
`define AMD_ST_LXI 8'h0A
`define AMD_ST_TBL 8'h11
// Idle states per skipped byte
`define AMD_SKIP_OP 8'h04
`define AMD_SKIP_IMM 8'h03
// Register file indexes
`define AMD_R_V 3'h0
`define AMD_R_A 3'h1
`define AMD_R_B 3'h2
`define AMD_R_C 3'h3
`define AMD_R_D 3'h4
`define AMD_R_E 3'h5
`define AMD_R_H 3'h6
`define AMD_R_L 3'h7
// Short register codes for the wide accumulator halves
`define AMD_S_WHI 3'h0
`define AMD_S_WLO 3'h1
// Pair codes of the word load
`define AMD_P_BC 3'h1
`define AMD_P_DE 3'h2
`define AMD_P_HL 3'h3
`define AMD_P_WA 3'h4
// Address arithmetic
`define AMD_TBL_OFS 16'h0003
`define AMD_STEP 8'h01
`endif

// ---- pkg/amd_pkg.sv ----
// Purpose: Types shared by the addressing and move decoder
// Assumes: Constants come from amd_defs.svh
// Notes: State codes are one-hot
package amd_pkg;
	// Sequencer states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_FETCH = 8'h02,
		ST_GET = 8'h04,
		ST_EXEC = 8'h08,
		ST_MWAIT = 8'h10,
		ST_LOAD1 = 8'h20,
		ST_LOAD2 = 8'h40,
		ST_HOLD = 8'h80
	} amd_state_t;
	// Instruction classes
	typedef enum logic [3:0] {
		CL_NOP = 4'h0,
		CL_MOVRA = 4'h1,
		CL_MOVAR = 4'h2,
		CL_SRW = 4'h3,
		CL_SRR = 4'h4,
		CL_LDM = 4'h5,
		CL_STM = 4'h6,
		CL_PAGE_DECREMENT_OP = 4'h7,
		CL_ADI = 4'h8,
		CL_LXI = 4'h9,
		CL_TBL = 4'hA
	} amd_cls_t;
endpackage

// ---- src/amd_decoder.sv ----
// Purpose: Fetch, decode and execute of addressing modes and 8-bit moves
// Assumes: Memory and special registers return data the cycle after a read strobe
// Notes: One instruction at a time; the state count is padded out in HOLD
`timescale 1ns/1ps
`default_nettype none
`include "amd_defs.svh"
module amd_decoder (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Pipeline side
	input wire logic i_start,
	input wire logic [15:0] i_pc,
	output logic o_busy,
	output logic o_done,
	output logic [15:0] o_pc_next,
	// Flag sets from the execute stage
	input wire logic i_skip_set,
	input wire logic i_str_acc_set,
	input wire logic i_str_low_set,
	output logic o_skip_flag,
	output logic o_str_acc,
	output logic o_str_low,
	// Memory bus
	output logic [15:0] o_mem_addr,
	output logic o_mem_rd,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	input wire logic [7:0] i_mem_rdata,
	// Special register port
	output logic o_sreg_wr,
	output logic o_sreg_rd,
	output logic [5:0] o_sreg_sel,
	output logic [7:0] o_sreg_wdata,
	input wire logic [7:0] i_sreg_rdata,
	// Architectural registers
	output logic [7:0][7:0] o_regfile,
	output logic [15:0] o_wide_acc
);
	logic rst_meta; // First reset stage
	logic rst_n; // Released reset
	amd_pkg::amd_state_t state; // Sequencer state
	logic [7:0] cnt; // States since first fetch
	logic [2:0] idx; // Next instruction byte
	logic [2:0] nlen; // Instruction length
	logic [7:0] ibuf [4]; // Instruction bytes
	logic [15:0] pc; // Instruction address
	logic skipping; // Instruction is skipped
	logic phase; // Second table read pending
	amd_pkg::amd_cls_t cls; // Decoded class
	logic [2:0] cur_len; // Length known at this byte
	logic more; // Another byte to fetch
	logic fetch_go; // Fetch strobe now
	logic [15:0] fetch_addr; // Fetch address
	logic [7:0] total; // States this instruction owes
	logic [2:0] opb; // Opcode bytes for skip cost
	logic needs_read; // Execute waits for data
	logic last; // Final state of instruction

	// Length follows from the first byte alone
	function automatic logic [2:0] len_of(input logic [7:0] b);
		if (b[7:3] == `AMD_OP_MOVRA || b[7:3] == `AMD_OP_MOVAR)
			return 3'h1;
		else if (b == `AMD_OP_PAGE_DECREMENT_OP || b == `AMD_OP_ADI || b == `AMD_OP_TBL)
			return 3'h2;
		else if (b == `AMD_OP_SRW || b == `AMD_OP_SRR)
			return 3'h2;
		else if (!b[7] && b[3:0] == `AMD_OP_LXI)
			return 3'h3;
		else if (b == `AMD_OP_PFX)
			return 3'h4;
		else
			return 3'h1;
	endfunction

	// Class from opcode and second byte
	function automatic amd_pkg::amd_cls_t cls_of(input logic [7:0] b0, input logic [7:0] b1);
		if (b0[7:3] == `AMD_OP_MOVRA)
			return amd_pkg::CL_MOVRA;
		else if (b0[7:3] == `AMD_OP_MOVAR)
			return amd_pkg::CL_MOVAR;
		else if (b0 == `AMD_OP_PAGE_DECREMENT_OP)
			return amd_pkg::CL_PAGE_DECREMENT_OP;
		else if (b0 == `AMD_OP_ADI)
			return amd_pkg::CL_ADI;
		else if (!b0[7] && b0[3:0] == `AMD_OP_LXI)
			return amd_pkg::CL_LXI;
		else if (b0 == `AMD_OP_TBL && b1 == `AMD_SUB_TBL)
			return amd_pkg::CL_TBL;
		else if (b0 == `AMD_OP_SRW && b1[7:6] == `AMD_SR_TAG)
			return amd_pkg::CL_SRW;
		else if (b0 == `AMD_OP_SRR && b1[7:6] == `AMD_SR_TAG)
			return amd_pkg::CL_SRR;
		else if (b0 == `AMD_OP_PFX && b1[7:3] == `AMD_SUB_LDM)
			return amd_pkg::CL_LDM;
		else if (b0 == `AMD_OP_PFX && b1[7:3] == `AMD_SUB_STM)
			return amd_pkg::CL_STM;
		else
			return amd_pkg::CL_NOP;
	endfunction

	// Writable special register codes
	function automatic logic sr_wr_ok(input logic [5:0] c);
		return (c <= 6'h03) || (c >= 6'h05 && c <= 6'h0D) || (c >= 6'h10 && c <= 6'h14)
			|| c == 6'h17 || c == 6'h18 || c == 6'h1A || c == 6'h1B || c == 6'h28;
	endfunction

	// Readable special register codes
	function automatic logic sr_rd_ok(input logic [5:0] c);
		return (c <= 6'h03) || (c >= 6'h05 && c <= 6'h09) || c == 6'h0B || c == 6'h0D
			|| c == 6'h19 || (c >= 6'h20 && c <= 6'h23);
	endfunction

	// Reset release through two stages
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Decode helpers and state budget
	always_comb begin
		cls = cls_of(ibuf[0], ibuf[1]);
		cur_len = (idx == 3'h0) ? len_of(i_mem_rdata) : nlen;
		more = (3'(idx + 3'h1) < cur_len);
		fetch_go = (state == amd_pkg::ST_IDLE && i_start) || (state == amd_pkg::ST_GET && more);
		fetch_addr = (state == amd_pkg::ST_IDLE) ? i_pc : 16'(pc + {13'h0000, idx} + 16'h0001);
		// Prefixed forms spend two opcode bytes
		opb = (cls == amd_pkg::CL_LDM || cls == amd_pkg::CL_STM || cls == amd_pkg::CL_TBL)
			? 3'h2 : 3'h1;
		case (cls)
			amd_pkg::CL_MOVRA, amd_pkg::CL_MOVAR: total = `AMD_ST_MOV1;
			amd_pkg::CL_SRW, amd_pkg::CL_SRR: total = `AMD_ST_SR;
			amd_pkg::CL_LDM, amd_pkg::CL_STM: total = `AMD_ST_DIR;
			amd_pkg::CL_PAGE_DECREMENT_OP: total = `AMD_ST_PAGE_DECREMENT_OP;
			amd_pkg::CL_ADI: total = `AMD_ST_ADI;
			amd_pkg::CL_LXI: total = `AMD_ST_LXI;
			amd_pkg::CL_TBL: total = `AMD_ST_TBL;
			default: total = `AMD_ST_MOV1;
		endcase
		// Skipped cost replaces the executed one
		if (skipping)
			total = 8'(`AMD_SKIP_OP * {5'h00, opb} + `AMD_SKIP_IMM * {5'h00, 3'(nlen - opb)});
		case (cls)
			amd_pkg::CL_LDM, amd_pkg::CL_PAGE_DECREMENT_OP, amd_pkg::CL_TBL: needs_read = !skipping;
			amd_pkg::CL_SRR: needs_read = !skipping && sr_rd_ok(ibuf[1][5:0]);
			default: needs_read = 1'b0;
		endcase
		// Unknown multi-byte opcodes reach HOLD past their budget; end them there, not on wrap
		last = (state == amd_pkg::ST_HOLD) && (cnt >= 8'(total - 8'h01));
	end

	// Sequencer: fetch bytes, execute, pad to the state count
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= amd_pkg::ST_IDLE;
			cnt <= 8'h00;
			idx <= 3'h0;
			nlen <= 3'h1;
			for (int i = 0; i < 4; i++)
				ibuf[i] <= 8'h00;
			pc <= 16'h0000;
			skipping <= 1'b0;
			phase <= 1'b0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_pc_next <= 16'h0000;
		end else begin
			o_done <= 1'b0;
			cnt <= 8'(cnt + 8'h01);
			case (state)
				amd_pkg::ST_IDLE: begin
					cnt <= 8'h00;
					if (i_start) begin
						pc <= i_pc;
						skipping <= o_skip_flag;
						idx <= 3'h0;
						phase <= 1'b0;
						for (int i = 0; i < 4; i++)
							ibuf[i] <= 8'h00;
						o_busy <= 1'b1;
						state <= amd_pkg::ST_FETCH;
					end
				end
				amd_pkg::ST_FETCH: state <= amd_pkg::ST_GET;
				amd_pkg::ST_GET: begin
					// Bytes land in order, so a word is low then high
					ibuf[idx[1:0]] <= i_mem_rdata;
					nlen <= cur_len;
					idx <= 3'(idx + 3'h1);
					state <= more ? amd_pkg::ST_FETCH : amd_pkg::ST_EXEC;
				end
				amd_pkg::ST_EXEC: begin
					o_pc_next <= 16'(pc + {13'h0000, nlen});
					state <= needs_read ? amd_pkg::ST_MWAIT : amd_pkg::ST_HOLD;
				end
				amd_pkg::ST_MWAIT: state <= phase ? amd_pkg::ST_LOAD2 : amd_pkg::ST_LOAD1;
				amd_pkg::ST_LOAD1: begin
					// Table needs a second byte from the next address
					phase <= (cls == amd_pkg::CL_TBL);
					state <= (cls == amd_pkg::CL_TBL) ? amd_pkg::ST_MWAIT : amd_pkg::ST_HOLD;
				end
				amd_pkg::ST_LOAD2: state <= amd_pkg::ST_HOLD;
				amd_pkg::ST_HOLD: begin
					if (last) begin
						state <= amd_pkg::ST_IDLE;
						o_done <= 1'b1;
						o_busy <= 1'b0;
					end
				end
				default: state <= amd_pkg::ST_IDLE;
			endcase
		end
	end

	// Memory and special register strobes; skipped work issues none
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_mem_addr <= 16'h0000;
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_mem_wdata <= 8'h00;
			o_sreg_wr <= 1'b0;
			o_sreg_rd <= 1'b0;
			o_sreg_sel <= 6'h00;
			o_sreg_wdata <= 8'h00;
		end else begin
			o_mem_rd <= 1'b0;
			o_mem_wr <= 1'b0;
			o_sreg_wr <= 1'b0;
			o_sreg_rd <= 1'b0;
			if (fetch_go) begin
				o_mem_rd <= 1'b1;
				o_mem_addr <= fetch_addr;
			end else if (state == amd_pkg::ST_EXEC && !skipping) begin
				case (cls)
					amd_pkg::CL_PAGE_DECREMENT_OP: begin
						o_mem_rd <= 1'b1;
						o_mem_addr <= {o_regfile[`AMD_R_V], ibuf[1]};
					end
					amd_pkg::CL_TBL: begin
						// Plain 16-bit add, carry out dropped
						o_mem_rd <= 1'b1;
						o_mem_addr <= 16'(pc + `AMD_TBL_OFS + {8'h00, o_regfile[`AMD_R_A]});
					end
					amd_pkg::CL_LDM: begin
						o_mem_rd <= 1'b1;
						o_mem_addr <= {ibuf[3], ibuf[2]};
					end
					amd_pkg::CL_STM: begin
						o_mem_wr <= 1'b1;
						o_mem_addr <= {ibuf[3], ibuf[2]};
						o_mem_wdata <= o_regfile[ibuf[1][2:0]];
					end
					amd_pkg::CL_SRW: begin
						o_sreg_wr <= sr_wr_ok(ibuf[1][5:0]);
						o_sreg_sel <= ibuf[1][5:0];
						o_sreg_wdata <= o_regfile[`AMD_R_A];
					end
					amd_pkg::CL_SRR: begin
						o_sreg_rd <= sr_rd_ok(ibuf[1][5:0]);
						o_sreg_sel <= ibuf[1][5:0];
					end
					default: o_mem_rd <= 1'b0;
				endcase
			end else if (state == amd_pkg::ST_LOAD1) begin
				if (cls == amd_pkg::CL_PAGE_DECREMENT_OP) begin
					o_mem_wr <= 1'b1;
					o_mem_wdata <= 8'(i_mem_rdata - `AMD_STEP);
				end else if (cls == amd_pkg::CL_TBL) begin
					o_mem_rd <= 1'b1;
					o_mem_addr <= 16'(o_mem_addr + 16'h0001);
				end
			end
		end
	end

	// Architectural register updates
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_regfile <= '0;
			o_wide_acc <= 16'h0000;
		end else if (state == amd_pkg::ST_EXEC && !skipping) begin
			case (cls)
				amd_pkg::CL_MOVRA: begin
					if (ibuf[0][2:0] == `AMD_S_WHI)
						o_wide_acc[15:8] <= o_regfile[`AMD_R_A];
					else if (ibuf[0][2:0] == `AMD_S_WLO)
						o_wide_acc[7:0] <= o_regfile[`AMD_R_A];
					else
						o_regfile[ibuf[0][2:0]] <= o_regfile[`AMD_R_A];
				end
				amd_pkg::CL_MOVAR: begin
					if (ibuf[0][2:0] == `AMD_S_WHI)
						o_regfile[`AMD_R_A] <= o_wide_acc[15:8];
					else if (ibuf[0][2:0] == `AMD_S_WLO)
						o_regfile[`AMD_R_A] <= o_wide_acc[7:0];
					else
						o_regfile[`AMD_R_A] <= o_regfile[ibuf[0][2:0]];
				end
				amd_pkg::CL_ADI: o_regfile[`AMD_R_A] <= 8'(o_regfile[`AMD_R_A] + ibuf[1]);
				amd_pkg::CL_LXI: begin
					// Pair codes outside the modelled set are ignored
					case (ibuf[0][6:4])
						`AMD_P_BC: {o_regfile[`AMD_R_B], o_regfile[`AMD_R_C]} <= {ibuf[2], ibuf[1]};
						`AMD_P_DE: {o_regfile[`AMD_R_D], o_regfile[`AMD_R_E]} <= {ibuf[2], ibuf[1]};
						`AMD_P_HL: {o_regfile[`AMD_R_H], o_regfile[`AMD_R_L]} <= {ibuf[2], ibuf[1]};
						`AMD_P_WA: o_wide_acc <= {ibuf[2], ibuf[1]};
						default: o_wide_acc <= o_wide_acc;
					endcase
				end
				default: o_wide_acc <= o_wide_acc;
			endcase
		end else if (state == amd_pkg::ST_LOAD1) begin
			if (cls == amd_pkg::CL_SRR)
				o_regfile[`AMD_R_A] <= i_sreg_rdata;
			else if (cls == amd_pkg::CL_LDM)
				o_regfile[ibuf[1][2:0]] <= i_mem_rdata;
			else if (cls == amd_pkg::CL_TBL)
				o_regfile[`AMD_R_C] <= i_mem_rdata;
		end else if (state == amd_pkg::ST_LOAD2) begin
			o_regfile[`AMD_R_B] <= i_mem_rdata;
		end
	end

	// Flags: a set in the closing cycle beats the clear
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_skip_flag <= 1'b0;
			o_str_acc <= 1'b0;
			o_str_low <= 1'b0;
		end else begin
			o_skip_flag <= i_skip_set || (o_skip_flag && !last);
			o_str_acc <= i_str_acc_set || (o_str_acc && !last);
			o_str_low <= i_str_low_set || (o_str_low && !last);
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!rst_n);
	sequence s_fetch;
		state == amd_pkg::ST_FETCH ##1 state == amd_pkg::ST_GET;
	endsequence
	logic exec_live; // Executed instruction in EXEC
	assign exec_live = state == amd_pkg::ST_EXEC && !skipping;
	page_addr_a: assert property (exec_live && cls == amd_pkg::CL_PAGE_DECREMENT_OP |=> o_mem_rd && o_mem_addr == {o_regfile[`AMD_R_V], ibuf[1]}) else $error("page address wrong");
	decr_back_a: assert property (state == amd_pkg::ST_LOAD1 && cls == amd_pkg::CL_PAGE_DECREMENT_OP |=> o_mem_wr && o_mem_wdata == 8'($past(i_mem_rdata) - 8'h01)) else $error("decrement write wrong");
	table_addr_a: assert property (exec_live && cls == amd_pkg::CL_TBL |=> o_mem_addr == 16'($past(pc) + 16'h0003 + {8'h00, $past(o_regfile[`AMD_R_A])}) ##2 o_mem_addr == 16'($past(o_mem_addr, 2) + 16'h0001)) else $error("table address wrong");
	imm_add_a: assert property (exec_live && cls == amd_pkg::CL_ADI |=> o_regfile[`AMD_R_A] == 8'($past(o_regfile[`AMD_R_A]) + $past(ibuf[1]))) else $error("immediate add wrong");
	direct_addr_a: assert property (exec_live && (cls == amd_pkg::CL_LDM || cls == amd_pkg::CL_STM) |=> o_mem_addr == {$past(ibuf[3]), $past(ibuf[2])}) else $error("direct address wrong");
	skip_quiet_a: assert property (skipping && state != amd_pkg::ST_IDLE && !fetch_go |=> !o_mem_wr && !o_sreg_wr && !o_sreg_rd) else $error("skipped work acted");
	fetch_pair_a: assert property (state == amd_pkg::ST_IDLE && i_start |=> s_fetch) else $error("fetch sequence wrong");
	move_time_a: assert property (o_done && $past(cls) == amd_pkg::CL_MOVRA |-> $past(cnt) == 8'h03) else $error("short move not 4 states");
	sr_time_a: assert property (o_done && $past(cls) == amd_pkg::CL_SRW |-> $past(cnt) == ($past(skipping) ? 8'h06 : 8'h09)) else $error("special write time wrong");
	dir_time_a: assert property (o_done && $past(cls) == amd_pkg::CL_LDM |-> $past(cnt) == ($past(skipping) ? 8'h0D : 8'h10)) else $error("direct load time wrong");
	flags_clear_a: assert property (o_done |-> (!o_skip_flag || $past(i_skip_set)) && (!o_str_acc || $past(i_str_acc_set))) else $error("flags not cleared");
	reserved_a: assert property (exec_live && cls == amd_pkg::CL_SRW && !sr_wr_ok(ibuf[1][5:0]) |=> !o_sreg_wr) else $error("reserved code written");
endmodule
`default_nettype wire

// ---- testbench/addr_mode_and_move_decoder_tb.sv ----
// Purpose: Self-checking bench for the addressing and move decoder
// Assumes: Integer model of registers, memory and special registers
// Notes: Instructions are placed in the memory model before each start
`timescale 1ns/1ps
`default_nettype none
module addr_mode_and_move_decoder_tb;
	logic i_mclk, i_rst_n, i_start, i_skip_set, i_str_acc_set, i_str_low_set;
	logic [15:0] i_pc, o_pc_next, o_mem_addr, o_wide_acc;
	logic o_busy, o_done, o_skip_flag, o_str_acc, o_str_low;
	logic o_mem_rd, o_mem_wr, o_sreg_wr, o_sreg_rd;
	logic [7:0] o_mem_wdata, i_mem_rdata, o_sreg_wdata, i_sreg_rdata;
	logic [5:0] o_sreg_sel;
	logic [7:0][7:0] o_regfile;
	int bad_count = 0; // Mismatches
	int n_checks = 0; // Comparisons made
	int er [8]; // Expected V A B C D E H L
	int ewa, tick; // Expected wide accumulator, cycle counter
	int sr [64]; // Expected special registers
	logic [7:0] d, lo, hi;
	logic [15:0] a;
	logic [31:0] sk_code [0:7] = '{32'h1A, 32'hC54D, 32'hFF807A70, 32'h7730, 32'h5546,
		32'h12340034, 32'hA048, 32'hFF806970};
	int sk_n [0:7] = '{1, 2, 4, 2, 2, 3, 2, 4};
	int sk_cost [0:7] = '{4, 7, 14, 7, 7, 10, 8, 14};
	localparam logic [15:0] PC0 = 16'h0100; // Program area, kept clear of data
	amd_decoder dut_u (.i_mclk, .i_rst_n, .i_start, .i_pc, .o_busy, .o_done, .o_pc_next,
		.i_skip_set, .i_str_acc_set, .i_str_low_set, .o_skip_flag, .o_str_acc, .o_str_low,
		.o_mem_addr, .o_mem_rd, .o_mem_wr, .o_mem_wdata, .i_mem_rdata, .o_sreg_wr,
		.o_sreg_rd, .o_sreg_sel, .o_sreg_wdata, .i_sreg_rdata, .o_regfile, .o_wide_acc);
	amd_mem_model mem_u (.i_mclk(i_mclk), .i_mem_addr(o_mem_addr), .i_mem_rd(o_mem_rd),
		.i_mem_wr(o_mem_wr), .i_mem_wdata(o_mem_wdata), .o_mem_rdata(i_mem_rdata),
		.i_sreg_wr(o_sreg_wr), .i_sreg_rd(o_sreg_rd), .i_sreg_sel(o_sreg_sel),
		.i_sreg_wdata(o_sreg_wdata), .o_sreg_rdata(i_sreg_rdata));
	// 250 MHz core clock
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	// Writable and readable special register codes
	function automatic bit is_w(input int c);
		return c <= 3 || (c >= 5 && c <= 13) || (c >= 16 && c <= 20) || c == 23 || c == 24
			|| c == 26 || c == 27 || c == 40;
	endfunction
	function automatic bit is_r(input int c);
		return c <= 3 || (c >= 5 && c <= 9) || c == 11 || c == 13 || c == 25
			|| (c >= 32 && c <= 35);
	endfunction
	task automatic end_sim();
		if (bad_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_cyc(input string nm, input int exp, input int got);
		n_checks++;
		if (got != exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	// Place the bytes, start, time to done, then compare every register with the model
	task automatic step(input logic [31:0] code, input int n, input logic [15:0] pc,
		input int ecyc);
		int cyc;
		for (int i = 0; i < n; i++) begin
			mem_u.mem[16'(pc + i)] = code[8*i +: 8];
		end
		@(posedge i_mclk);
		i_start <= 1'b1;
		i_pc <= pc;
		@(posedge i_mclk);
		i_start <= 1'b0;
		cyc = 0;
		do begin
			@(posedge i_mclk);
			#1;
			cyc++;
			if (cyc == 1) chk_val("busy", 16'h0001, {15'h0000, o_busy});
		end while (o_done !== 1'b1 && cyc < 40);
		chk_cyc("states", ecyc, cyc);
		chk_val("busy_at_done", 16'h0000, {15'h0000, o_busy});
		chk_val("pc_next", 16'(pc + n), o_pc_next);
		for (int i = 0; i < 8; i++) begin
			chk_val("regfile", 16'(er[i]), {8'h00, o_regfile[i]});
		end
		chk_val("wide_acc", 16'(ewa), o_wide_acc);
		chk_val("flags", 16'h0000, {13'h0000, o_skip_flag, o_str_acc, o_str_low});
	endtask
	// One-cycle pulse on the flag set inputs
	task automatic pulse(input logic [2:0] f);
		@(posedge i_mclk);
		{i_skip_set, i_str_acc_set, i_str_low_set} <= f;
		@(posedge i_mclk);
		{i_skip_set, i_str_acc_set, i_str_low_set} <= 3'b000;
		#1;
		chk_val("flag_set", 16'(f), {13'h0000, o_skip_flag, o_str_acc, o_str_low});
	endtask
	// Add an immediate byte to A, keeping the model in step
	task automatic add_imm(input logic [7:0] v);
		er[1] = (er[1] + v) & 255;
		step({16'h0000, v, 8'h46}, 2, PC0, 7);
	endtask
	// Hang guard: a stuck handshake ends the run as a failure
	always @(posedge i_mclk) begin
		tick++;
		if (tick == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	initial begin
		void'($urandom(83));
		{i_rst_n, i_start, i_pc, i_skip_set, i_str_acc_set, i_str_low_set} = '0;
		tick = 0;
		ewa = 0;
		foreach (er[i]) er[i] = 0;
		foreach (sr[i]) sr[i] = (i * 37 + 5) & 255;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_mclk);
		#1;
		chk_val("reset_wide_acc", 16'h0000, o_wide_acc);
		// Every short register code, both directions, with string flags set before each accumulator to register move
		for (int c = 0; c < 8; c++) begin
			add_imm(8'($urandom));
			if (c == 0) ewa = (ewa & 255) | (er[1] << 8);
			else if (c == 1) ewa = (ewa & 16'hFF00) | er[1];
			else er[c] = er[1];
			pulse(3'b011);
			step(32'(8'h18 | c), 1, PC0, 4);
		end
		for (int c = 0; c < 8; c++) begin
			er[1] = (c == 0) ? ewa >> 8 : (c == 1) ? ewa & 255 : er[c];
			step(32'(8'h08 | c), 1, PC0, 4);
		end
		// Word operands, low byte first
		for (int p = 1; p < 5; p++) begin
			lo = 8'($urandom);
			hi = 8'($urandom);
			if (p == 4) ewa = {hi, lo};
			else begin
				er[2 * p] = hi;
				er[2 * p + 1] = lo;
			end
			step({8'h00, hi, lo, 8'(p << 4 | 4)}, 3, PC0, 10);
		end
		// Direct loads and stores for every register code
		for (int r = 0; r < 8; r++) begin
			a = 16'h8000 | 16'($urandom);
			d = (r == 0) ? 8'($urandom) | 8'h90 : 8'($urandom);
			mem_u.mem[a] = d;
			er[r] = d;
			step({a[15:8], a[7:0], 8'(8'h68 | r), 8'h70}, 4, PC0, 17);
		end
		for (int r = 0; r < 8; r++) begin
			a = 16'h8000 | 16'($urandom);
			step({a[15:8], a[7:0], 8'(8'h78 | r), 8'h70}, 4, PC0, 17);
			chk_val("stored", 16'(er[r]), {8'h00, mem_u.mem[a]});
		end
		// Page decrement, including the zero to all-ones boundary
		for (int k = 0; k < 2; k++) begin
			lo = 8'($urandom);
			a = {8'(er[0]), lo};
			d = (k == 0) ? 8'h00 : 8'($urandom);
			mem_u.mem[a] = d;
			step({16'h0000, lo, 8'h30}, 2, PC0, 10);
			chk_val("page_byte", 16'((d - 1) & 255), {8'h00, mem_u.mem[a]});
		end
		// Table lookup near the top of memory so the address wraps
		for (int k = 0; k < 2; k++) begin
			add_imm(8'(((k == 0 ? 255 : 12) - er[1]) & 255));
			a = 16'(16'hFFF0 + 3 + er[1]);
			mem_u.mem[a] = 8'($urandom);
			mem_u.mem[16'(a + 1)] = 8'($urandom);
			er[3] = mem_u.mem[a];
			er[2] = mem_u.mem[16'(a + 1)];
			step(32'h0000A048, 2, 16'hFFF0, 17);
		end
		// All 64 special register codes, written then read back
		for (int c = 0; c < 64; c++) begin
			add_imm(8'($urandom));
			if (is_w(c)) sr[c] = er[1];
			step({16'h0000, 2'b11, 6'(c), 8'h4D}, 2, PC0, 10);
			chk_val("sreg", 16'(sr[c]), {8'h00, mem_u.sreg[c]});
			if (is_r(c)) er[1] = sr[c];
			step({16'h0000, 2'b11, 6'(c), 8'h4D ^ 8'h01}, 2, PC0, 10);
		end
		// Skipped instructions cost idle states and change nothing
		mem_u.mem[16'hFF80] = 8'(~er[1]);
		for (int k = 0; k < 8; k++) begin
			pulse(3'b111);
			step(sk_code[k], sk_n[k], PC0, sk_cost[k]);
		end
		chk_val("skip_store", 16'(8'(~er[1])), {8'h00, mem_u.mem[16'hFF80]});
		chk_val("skip_sreg", 16'(sr[5]), {8'h00, mem_u.sreg[5]});
		end_sim();
	end
endmodule
`default_nettype wire

// ---- testbench/amd_mem_model.sv ----
// Purpose: Program/data memory and special registers facing the decoder
// Assumes: Read data is returned the cycle after a strobe
// Notes: Stale read lines invert each cycle so a late sample is seen
`timescale 1ns/1ps
`default_nettype none
module amd_mem_model (
	// Clock
	input wire logic i_mclk,
	// Memory bus
	input wire logic [15:0] i_mem_addr,
	input wire logic i_mem_rd,
	input wire logic i_mem_wr,
	input wire logic [7:0] i_mem_wdata,
	output logic [7:0] o_mem_rdata,
	// Special register port
	input wire logic i_sreg_wr,
	input wire logic i_sreg_rd,
	input wire logic [5:0] i_sreg_sel,
	input wire logic [7:0] i_sreg_wdata,
	output logic [7:0] o_sreg_rdata
);
	logic [7:0] mem [0:65535]; // Byte store, preloaded by the bench
	logic [7:0] sreg [0:63]; // Every code answers, so reserved access shows
	// Known contents everywhere so no unknown reaches the decoder
	initial begin
		o_mem_rdata = 8'hA5;
		o_sreg_rdata = 8'h5A;
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i ^ (i >> 8));
		end
		for (int i = 0; i < 64; i++) begin
			sreg[i] = 8'(i * 37 + 5);
		end
	end
	// Synchronous memory: data for one cycle, then garbage
	always @(posedge i_mclk) begin
		if (i_mem_rd) begin
			o_mem_rdata <= mem[i_mem_addr];
		end else begin
			o_mem_rdata <= ~o_mem_rdata;
		end
		if (i_mem_wr) begin
			mem[i_mem_addr] <= i_mem_wdata;
		end
	end
	// Special registers with the same one-cycle answer
	always @(posedge i_mclk) begin
		if (i_sreg_rd) begin
			o_sreg_rdata <= sreg[i_sreg_sel];
		end else begin
			o_sreg_rdata <= ~o_sreg_rdata;
		end
		if (i_sreg_wr) begin
			sreg[i_sreg_sel] <= i_sreg_wdata;
		end
	end
endmodule
`default_nettype wire
